//--- core/secwrs_pkg.sv
// Purpose: Shared constants and types of the two-wire memory slave core.
// Assumes: 20 MHz system clock; 8K x 8 array split into 4K-bit blocks.
// Notes:   Timing counts are derived from the printed times below.
package secwrs_pkg;

  // Control byte type code and byte field positions.
  localparam logic [3:0] CTRL_CODE    = 4'hA;
  localparam int         ADR_SEC_BIT  = 7;
  localparam int         BLK_MSB      = 4;
  localparam int         BLK_LSB      = 1;
  localparam int         CFG_SEL_BIT  = 7;
  localparam int         CFG_RD_BIT   = 6;
  localparam int         BLK_ADDR_LSB = 9;

  // Bit slot numbers within one nine-clock byte frame.
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;
  localparam logic [3:0] PRE_BIT       = 4'hF;

  // Array and cache geometry.
  localparam int ADDR_W    = 13;
  localparam int MEM_BYTES = 8192;
  localparam int CACHE_AW  = 6;
  localparam int CACHE_LEN = 64;
  localparam int PAGES     = 8;
  localparam int PAGE_LEN  = 8;

  // Factory state of the nonvolatile configuration.
  localparam logic [3:0] PROT_START_RST = 4'hF;
  localparam logic [3:0] PROT_COUNT_RST = 4'h0;
  localparam logic [3:0] HE_BLK_RST     = 4'hF;
  localparam logic [3:0] RB_UPPER       = 4'hF;

  // Self-timed write: one page takes T_WR_MS.
  localparam int CLK_HZ      = 20_000_000;
  localparam int T_WR_MS     = 5;
  localparam int WR_PAGE_CYC = T_WR_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    ST_IDLE, ST_CTRL, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_CFG, ST_RDATA
  } secwrs_state_t;

  typedef enum logic [1:0] {WR_IDLE, WR_BYTE, WR_WAIT} secwrs_wr_t;

  typedef struct packed {
    logic       locked;
    logic [3:0] he_blk;
    logic [3:0] start;
    logic [3:0] count;
  } secwrs_cfg_t;

endpackage

//--- core/secwrs_core.sv
// Purpose: Two-wire serial memory slave with 64-byte write cache,
//          block write protection and relocatable high-endurance block.
// Assumes: SCL, SDA and strap pins are asynchronous to sys_clk, and
//          SCL is much slower than sys_clk.
// Notes:   SDA is open drain: sda_oe high pulls the line low.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Contract
// RQ1: Write control byte acked, then high and low address bytes load pointer.
// RQ2: Internal write starts on STOP; no acknowledge while it runs.
// RQ3: Up to 64 data bytes held in cache, committed only after STOP.
// RQ4: Each data byte bumps the low six pointer bits; upper seven stay.
// RQ5: Past a full cache the cache pointer wraps and overwrites.
// RQ6: STOP may come anytime; abort by new START writes nothing.
// RQ7: Read control byte has read bit set; three read forms supported.
// RQ8: Current address read returns byte after last accessed location.
// RQ9: Random read keeps the pointer loaded by the aborted write.
// RQ10: Master ack asks for the next byte; nack plus STOP ends.
// RQ11: Pointer increments after every byte, whole array readable.
// RQ12: Master may use select bits as address bits 13 to 15.
// RQ13: Config byte bit 7 low relocates high-endurance block.
// RQ14: Relocation refused once locked; default is highest block.
// RQ15: Protection covers count blocks from start; set only once.
// RQ16: Factory protection state is start 15, count zero.
// RQ17: Protection command: address byte bit 7 set, start in bits 1-4.
// RQ18: Don't-care byte, then config byte with count in bits 0-3.
// RQ19: Protected addresses are skipped silently during commit.
// RQ20: Config byte with bit 6 set returns two readback bytes.
// RQ21: Readback bytes carry ones on top, start then count below.
// RQ22: Ack control byte only for code 1010 and matching straps.
// RQ23: Write control byte not acked while busy, acked after.
// RQ24: First byte lands at cache page 0, offset from low address bits.
// RQ25: Busy time is per-page cycles times pages loaded.
// RQ26: Configuration held in storage guarded by a one-time lock.
module secwrs_core
  import secwrs_pkg::*;
#(
  parameter int PAGE_CYC = WR_PAGE_CYC
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Two-wire link pins.
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Chip address straps.
  input  wire logic [2:0]  chip_select_inputs,
  // Status.
  output logic             write_busy,
  output secwrs_cfg_t      prot_cfg
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus condition detection.

  logic              scl_q1, scl_s, scl_d;
  logic              sda_q1, sda_s, sda_d;
  logic [2:0]        cs_q1, cs_s;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      {scl_q1, scl_s, scl_d} <= 3'h7;
      {sda_q1, sda_s, sda_d} <= 3'h7;
      cs_q1 <= 3'h0;
      cs_s  <= 3'h0;
    end else begin
      {scl_q1, scl_s, scl_d} <= {scl, scl_q1, scl_s};
      {sda_q1, sda_s, sda_d} <= {sda_in, sda_q1, sda_s};
      cs_q1 <= chip_select_inputs;
      cs_s  <= cs_q1;
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_ev  = scl_s & scl_d & ~sda_d & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Bit framing.

  logic [3:0]        bit_cnt;
  logic [7:0]        rx;
  logic              ack_seen;

  always_ff @(posedge sys_clk) begin
    if (sys_rst || start_ev || stop_ev) begin
      bit_cnt <= PRE_BIT; // The SCL fall that closes START is not a bit.
    end else if (scl_rise) begin
      if (bit_cnt == ACK_SLOT) begin
        ack_seen <= ~sda_s;
      end else begin
        rx <= {rx[6:0], sda_s};
      end
    end else if (scl_fall) begin
      bit_cnt <= (bit_cnt == ACK_SLOT) ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.

  secwrs_state_t     state, next_state;
  secwrs_wr_t        wst;
  logic [ADDR_W-1:0] ptr;
  logic              sec;
  logic [3:0]        sec_blk;
  logic              cfg_rd, cfg_second, cfg_got;
  logic [7:0]        cfg_byte;
  logic [7:0]        tx;
  logic [9:0]        base_page;
  logic [CACHE_AW-1:0] wptr, cidx;
  logic [CACHE_LEN-1:0] valid;
  logic [PAGES-1:0]  page_used;
  logic [31:0]       timer;
  logic [7:0]        cache [CACHE_LEN];
  logic [7:0]        mem [MEM_BYTES];

  wire byte_end = scl_fall & (bit_cnt == LAST_DATA_BIT);
  wire ack_end  = scl_fall & (bit_cnt == ACK_SLOT);
  wire ctrl_hit = (rx[7:4] == CTRL_CODE) & (rx[3:1] == cs_s);
  wire ctrl_ok  = ctrl_hit & ~write_busy; // see RQ2 RQ22 RQ23
  wire in_write = (state == ST_ADDR_HI) | (state == ST_ADDR_LO) |
                  (state == ST_WDATA) | (state == ST_CFG);
  wire ack_now  = byte_end & ((state == ST_CTRL) ? ctrl_ok : in_write);
  wire wr_byte_ev = byte_end & (state == ST_WDATA);
  wire rd_load  = ack_end & (state == ST_RDATA) & ack_seen; // see RQ10
  wire [3:0] rb_low = cfg_second ? prot_cfg.count : prot_cfg.start;
  wire [7:0] rd_byte = cfg_rd ? {RB_UPPER, rb_low} : mem[ptr]; // see RQ21
  wire commit_go = stop_ev & (state == ST_WDATA) & (|valid);

  always_comb begin
    next_state = state;
    if (start_ev) begin
      next_state = ST_CTRL;
    end else if (stop_ev) begin
      next_state = ST_IDLE;
    end else if (byte_end) begin
      case (state)
        ST_CTRL: begin
          if (!ctrl_ok) next_state = ST_IDLE;
          else next_state = rx[0] ? ST_RDATA : ST_ADDR_HI; // see RQ7 RQ1
        end
        ST_ADDR_HI: next_state = ST_ADDR_LO;
        ST_ADDR_LO: next_state = sec ? ST_CFG : ST_WDATA; // see RQ18
        ST_CFG:     next_state = rx[CFG_RD_BIT] ? ST_RDATA : ST_CFG;
        default:    next_state = state;
      endcase
    end else if (ack_end && state == ST_RDATA && !ack_seen) begin
      next_state = ST_IDLE; // see RQ8 RQ10
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) state <= ST_IDLE;
    else state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // SDA drive: acknowledge bits and read data, changed on SCL falls.

  always_ff @(posedge sys_clk) begin
    if (sys_rst || start_ev || stop_ev) begin
      sda_oe <= 1'b0;
    end else if (byte_end) begin
      sda_oe <= ack_now; // see RQ1 RQ17
    end else if (ack_end) begin
      sda_oe <= rd_load & ~rd_byte[7];
    end else if (scl_fall && state == ST_RDATA) begin
      sda_oe <= ~tx[6];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) tx <= 8'hFF;
    else if (rd_load) tx <= rd_byte;
    else if (scl_fall && state == ST_RDATA) tx <= {tx[6:0], 1'b1};
  end
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Address pointer and cache loading.

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ptr       <= '0;
      sec       <= 1'b0;
      sec_blk   <= 4'h0;
      base_page <= '0;
      wptr      <= '0;
      valid     <= '0;
    end else if (start_ev && state == ST_WDATA) begin
      valid <= '0; // see RQ6
    end else if (byte_end && state == ST_ADDR_HI) begin
      sec     <= rx[ADR_SEC_BIT]; // see RQ17
      sec_blk <= rx[BLK_MSB:BLK_LSB];
      if (!rx[ADR_SEC_BIT]) ptr[12:8] <= rx[4:0];
    end else if (byte_end && state == ST_ADDR_LO && !sec) begin
      ptr[7:0]  <= rx; // see RQ9
      base_page <= {ptr[12:8], rx[7:3]};
      wptr      <= {3'h0, rx[2:0]}; // see RQ24
      valid     <= '0;
    end else if (wr_byte_ev) begin
      valid[wptr] <= 1'b1;
      wptr <= wptr + 6'h1; // see RQ5
      ptr  <= {ptr[12:6], ptr[5:0] + 6'h1}; // see RQ4
    end else if (rd_load && !cfg_rd) begin
      ptr <= ptr + 13'h1; // see RQ8 RQ11
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_byte_ev) cache[wptr] <= rx; // see RQ3
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration command and readback. The lock is set by the first
  // protection command, and later relocation or protection is ignored.

  always_ff @(posedge sys_clk) begin
    if (sys_rst || start_ev) begin
      cfg_rd     <= 1'b0;
      cfg_second <= 1'b0;
      cfg_got    <= 1'b0;
    end else if (byte_end && state == ST_CFG && !cfg_got) begin
      cfg_byte <= rx;
      cfg_got  <= 1'b1;
      cfg_rd   <= rx[CFG_RD_BIT]; // see RQ20
    end else if (rd_load && cfg_rd) begin
      cfg_second <= 1'b1;
    end
  end

  wire cfg_apply = stop_ev & (state == ST_CFG) & cfg_got & ~prot_cfg.locked;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prot_cfg <= '{1'b0, HE_BLK_RST, PROT_START_RST, PROT_COUNT_RST}; // see RQ16
    end else if (cfg_apply && !cfg_byte[CFG_SEL_BIT]) begin
      prot_cfg.he_blk <= sec_blk; // see RQ13 RQ14
    end else if (cfg_apply && !cfg_byte[CFG_RD_BIT]) begin
      prot_cfg.start  <= sec_blk; // see RQ15 RQ26
      prot_cfg.count  <= cfg_byte[3:0];
      prot_cfg.locked <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed commit: one cache byte per cycle, then a page wait for
  // each page that held data. Waiting per page keeps the busy time
  // proportional to pages loaded without a population count.

  for (genvar g = 0; g < PAGES; g++) begin : g_page
    assign page_used[g] = |valid[g*PAGE_LEN +: PAGE_LEN];
  end

  wire [ADDR_W-1:0] mem_addr = {base_page, 3'h0} + {7'h0, cidx};
  wire [4:0] blk      = {1'b0, mem_addr[12:BLK_ADDR_LSB]};
  wire [4:0] blk_lo   = {1'b0, prot_cfg.start};
  wire [4:0] blk_hi   = blk_lo + {1'b0, prot_cfg.count};
  wire       prot_hit = (blk >= blk_lo) & (blk < blk_hi);
  wire       mem_we   = (wst == WR_BYTE) & valid[cidx] & ~prot_hit;
  wire       page_end = (cidx[2:0] == 3'h7);
  wire       last_idx = (cidx == 6'h3F);
  wire       wait_end = (timer == 32'(PAGE_CYC - 1));

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wst   <= WR_IDLE;
      cidx  <= '0;
      timer <= '0;
    end else begin
      case (wst)
        WR_IDLE: begin
          cidx <= '0;
          if (commit_go) wst <= WR_BYTE; // see RQ2 RQ3
        end
        WR_BYTE: begin
          timer <= '0;
          if (page_end && page_used[cidx[5:3]]) wst <= WR_WAIT; // see RQ25
          else if (last_idx) wst <= WR_IDLE;
          else cidx <= cidx + 6'h1;
        end
        WR_WAIT: begin
          timer <= timer + 32'h1;
          if (wait_end) begin
            wst  <= last_idx ? WR_IDLE : WR_BYTE;
            cidx <= cidx + 6'h1;
          end
        end
        default: wst <= WR_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (mem_we) mem[mem_addr] <= cache[cidx]; // see RQ19 RQ24
  end

  assign write_busy = (wst != WR_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_no_ack_busy;
    byte_end && state == ST_CTRL && write_busy |=> !sda_oe;
  endproperty
  a_no_ack_busy: assert property (p_no_ack_busy) // see RQ2
    else $error("control byte acked during write cycle");

  property p_ctrl_ack;
    byte_end && state == ST_CTRL && !write_busy && rx[7:4] == 4'hA &&
    rx[3:1] == cs_s |=> sda_oe ##1 sda_oe;
  endproperty
  a_ctrl_ack: assert property (p_ctrl_ack) // see RQ22
    else $error("matching control byte not acknowledged");

  property p_wptr_inc;
    wr_byte_ev |=> wptr == $past(wptr) + 6'h1 &&
                   ptr[12:6] == $past(ptr[12:6]);
  endproperty
  a_wptr_inc: assert property (p_wptr_inc) // see RQ4
    else $error("cache or address pointer step wrong");

  property p_commit_stop;
    commit_go && !write_busy |=> write_busy [*2];
  endproperty
  a_commit_stop: assert property (p_commit_stop) // see RQ3
    else $error("write cycle did not start after stop");

  property p_abort;
    start_ev && state == ST_WDATA |=> valid == '0 && !write_busy;
  endproperty
  a_abort: assert property (p_abort) // see RQ6
    else $error("aborted write left cache data");

  property p_read_inc;
    rd_load && !cfg_rd |=> ptr == $past(ptr) + 13'h1;
  endproperty
  a_read_inc: assert property (p_read_inc) // see RQ11
    else $error("read pointer did not advance");

  property p_lock;
    prot_cfg.locked |=> $stable(prot_cfg);
  endproperty
  a_lock: assert property (p_lock) // see RQ15
    else $error("locked configuration changed");

  property p_protect;
    wst == WR_BYTE && prot_hit |=>
      mem[$past(mem_addr)] == $past(mem[mem_addr]);
  endproperty
  a_protect: assert property (p_protect) // see RQ19
    else $error("protected address written");

  property p_readback;
    rd_load && cfg_rd |=> tx[7:4] == 4'hF && sda_oe == 1'b0;
  endproperty
  a_readback: assert property (p_readback) // see RQ21
    else $error("readback upper bits not ones");

endmodule // secwrs_core

//--- sim/secwrs_master.sv
// Purpose: Behavioural two-wire bus master for the memory slave.
// Assumes: SCL period of 8 sys_clk cycles, pull-up on SDA.
// Notes:   It only pulls SDA low or releases it; SCL idles high.
`timescale 1ns/1ps
module secwrs_master (
  // Clock.
  input  wire logic sys_clk,
  // Bus wires.
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Data changes only while SCL is low, so no false START or STOP.
  task automatic bit_io(input logic d, output logic s);
    cyc(1);
    sda_low = ~d;
    cyc(4);
    scl = 1'b1;
    cyc(3);
    s = sda;
    scl = 1'b0;
  endtask

  task automatic start_c();
    cyc(1);
    sda_low = 1'b0;
    cyc(4);
    scl = 1'b1;
    cyc(4);
    sda_low = 1'b1;
    cyc(4);
    scl = 1'b0;
  endtask

  task automatic stop_c();
    cyc(1);
    sda_low = 1'b1;
    cyc(4);
    scl = 1'b1;
    cyc(4);
    sda_low = 1'b0;
    cyc(4);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // A master acknowledge asks for one more byte.
  task automatic rd_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(~ack, s);
  endtask
endmodule // secwrs_master

//--- sim/tb_top.sv
// Purpose: Self-checking bench of the two-wire memory slave core.
// Assumes: PAGE_CYC shortened to 20 cycles per page.
// Notes:   Expected array contents are kept in exp_mem.
`timescale 1ns/1ps
module tb_top
  import secwrs_pkg::*;
;
  localparam int PC = 20;
  logic        sys_clk;
  logic        sys_rst;
  logic        scl;
  logic        sda_low;
  logic        sda_out;
  logic        sda_oe;
  logic        write_busy;
  logic [2:0]  cs;
  wire         sda;
  secwrs_cfg_t prot_cfg;
  logic [7:0]  exp_mem [0:8191];
  logic [7:0]  ctl_w;
  logic [7:0]  ctl_r;
  int          err_total;
  int          checks;
  int          cycles;
  int          busy_cnt;

  assign sda   = ~(sda_low | (sda_oe & ~sda_out));
  assign ctl_w = {CTRL_CODE, cs, 1'b0};
  assign ctl_r = {CTRL_CODE, cs, 1'b1};

  secwrs_core #(.PAGE_CYC(PC)) u_secwrs_core (
    .sys_clk            (sys_clk),
    .sys_rst            (sys_rst),
    .scl                (scl),
    .sda_in             (sda),
    .sda_out            (sda_out),
    .sda_oe             (sda_oe),
    .chip_select_inputs (cs),
    .write_busy         (write_busy),
    .prot_cfg           (prot_cfg)
  );

  secwrs_master u_secwrs_master (
    .sys_clk (sys_clk),
    .sda     (sda),
    .scl     (scl),
    .sda_low (sda_low)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // The whole run needs about 15000 cycles.
  always @(posedge sys_clk) begin
    cycles++;
    if (write_busy === 1'b1) busy_cnt++;
    if (cycles == 80000) begin
      err_total++;
      report_and_stop();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wb(input logic [7:0] b, input logic exp_ack);
    logic a;
    u_secwrs_master.wr_byte(b, a);
    chk(a, exp_ack, "byte ack");
  endtask

  task automatic set_ptr(input logic [15:0] adr);
    u_secwrs_master.start_c();
    wb(ctl_w, 1'b1);
    wb(adr[15:8], 1'b1);
    wb(adr[7:0], 1'b1);
  endtask

  task automatic wait_idle();
    u_secwrs_master.cyc(3);
    for (int n = 0; n < 3000 && write_busy !== 1'b0; n++) begin
      u_secwrs_master.cyc(1);
    end
    chk(write_busy, 1'b0, "busy stuck");
  endtask

  task automatic rd_at(input logic [12:0] adr, input int n);
    logic [7:0] b;
    set_ptr({3'h0, adr});
    u_secwrs_master.start_c();
    wb(ctl_r, 1'b1);
    for (int k = 0; k < n; k++) begin
      u_secwrs_master.rd_byte(k < n - 1, b);
      chk(b, exp_mem[adr + 13'(k)], "read data");
    end
    u_secwrs_master.stop_c();
  endtask

  task automatic cfg(input logic [7:0] hi, input logic [7:0] c);
    set_ptr({hi, 8'h00});
    wb(c, 1'b1);
    u_secwrs_master.stop_c();
    wait_idle();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_refuse();
    u_secwrs_master.start_c();
    wb({CTRL_CODE, cs ^ 3'h1, 1'b0}, 1'b0);
    u_secwrs_master.start_c();
    wb({4'hB, cs, 1'b0}, 1'b0);
    u_secwrs_master.stop_c();
    // New straps move the part to another slot of address bits 15:13.
    cs = 3'h2;
    u_secwrs_master.start_c();
    wb({CTRL_CODE, 3'h5, 1'b0}, 1'b0);
    u_secwrs_master.start_c();
    wb(ctl_w, 1'b1);
    u_secwrs_master.stop_c();
    cs = 3'h5;
  endtask

  // Start at offset 5 and send 66 bytes so the cache wraps and overwrites.
  task automatic t_page();
    logic [7:0] b;
    set_ptr(16'h01E5);
    for (int i = 0; i < 66; i++) begin
      exp_mem[13'h01E0 + 13'((5 + i) % 64)] = 8'(i) + 8'h30;
      wb(8'(i) + 8'h30, 1'b1);
    end
    u_secwrs_master.stop_c();
    u_secwrs_master.cyc(2);
    chk(write_busy, 1'b1, "no busy");
    wait_idle();
    rd_at(13'h01E0, 63);
    u_secwrs_master.start_c();
    wb(ctl_r, 1'b1);
    u_secwrs_master.rd_byte(1'b0, b);
    chk(b, exp_mem[13'h021F], "current read");
    u_secwrs_master.stop_c();
  endtask

  task automatic t_abort();
    set_ptr(16'h01E0);
    wb(8'hEE, 1'b1);
    u_secwrs_master.start_c();
    u_secwrs_master.stop_c();
    u_secwrs_master.cyc(3);
    chk(write_busy, 1'b0, "abort busy");
    rd_at(13'h01E0, 1);
  endtask

  task automatic t_config();
    logic [7:0] b;
    cfg(8'h86, 8'h00);
    chk(prot_cfg.he_blk, 4'h3, "relocate");
    cfg(8'hE1, 8'hB1);
    chk(prot_cfg, {1'b1, 4'h3, 4'h0, 4'h1}, "protect");
    set_ptr(16'hE100);
    wb(8'hC0, 1'b1);
    u_secwrs_master.rd_byte(1'b1, b);
    chk(b, {RB_UPPER, 4'h0}, "readback start");
    u_secwrs_master.rd_byte(1'b0, b);
    chk(b, {RB_UPPER, 4'h1}, "readback count");
    u_secwrs_master.stop_c();
    cfg(8'h9E, 8'h8F);
    cfg(8'h8A, 8'h00);
    chk(prot_cfg, {1'b1, 4'h3, 4'h0, 4'h1}, "relock");
  endtask

  // Two bytes fall in protected block 0 and two in block 1.
  task automatic t_boundary();
    set_ptr(16'h01FE);
    for (int i = 0; i < 4; i++) wb(8'hC0 + 8'(i), 1'b1);
    exp_mem[13'h0200] = 8'hC2;
    exp_mem[13'h0201] = 8'hC3;
    busy_cnt = 0;
    u_secwrs_master.stop_c();
    u_secwrs_master.start_c();
    wb(ctl_w, 1'b0);
    u_secwrs_master.stop_c();
    wait_idle();
    chk(busy_cnt >= 62 + 2 * PC && busy_cnt <= 66 + 2 * PC, 1'b1,
        "busy length");
    u_secwrs_master.start_c();
    wb(ctl_w, 1'b1);
    u_secwrs_master.stop_c();
    rd_at(13'h01FC, 8);
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    checks    = 0;
    cycles    = 0;
    busy_cnt  = 0;
    cs        = 3'h5;
    sys_rst   = 1'b1;
    u_secwrs_master.cyc(3);
    sys_rst = 1'b0;
    u_secwrs_master.cyc(4);
    chk(prot_cfg, {1'b0, HE_BLK_RST, PROT_START_RST, PROT_COUNT_RST},
        "factory");
    t_refuse();
    t_page();
    t_abort();
    t_config();
    t_boundary();
    report_and_stop();
  end
endmodule // tb_top
